/* src/dha_pkg.sv */
// shared types and constants for the dual-lane add/sub alu
package dha_pkg;
  localparam int ACC_W = 40;
  localparam int LO_W = 16;
  localparam int HI_W = 24;
  localparam int GUARD_W = 8;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 16;
  localparam int INSTR_W = 24;
  localparam int INSTR_BYTES = 3;
  localparam int OVF_LO_BIT = 15;
  localparam int OVF_HI_BIT = 31;
  localparam int CARRY_BIT = 31;
  localparam int HI_LANE_OVF_BIT = OVF_HI_BIT - LO_W;
  localparam int HI_LANE_CARRY_BIT = CARRY_BIT - LO_W;
  localparam int OPC_W = 8;
  localparam int SUBOP_MSB = 3;
  localparam int SUBOP_LSB = 1;
  localparam logic [7:0] OPC_TMP_DUAL = 8'b1110_1110;
  localparam logic [2:0] SUB_ADD_TMP = 3'b100;
  localparam logic [2:0] SUB_MIX_DBL = 3'b110;
  localparam logic [LO_W-1:0] LO_SAT_POS = 16'h7fff;
  localparam logic [LO_W-1:0] LO_SAT_NEG = 16'h8000;
  localparam logic [HI_W-1:0] HI_SAT_POS = 24'h00_7fff;
  localparam logic [HI_W-1:0] HI_SAT_NEG = 24'hff_8000;
  localparam logic [ACC_W-1:0] ACC_RST = 40'h00_0000_0000;

  typedef enum logic [1:0] {
    DHA_OP_ADD_ACC_DBL,
    DHA_OP_ADD_TMP_DBL,
    DHA_OP_MIX_TMP_SGL,
    DHA_OP_MIX_TMP_DBL
  } dha_op_t;

  typedef struct packed {
    logic sign_extend_mode;
    logic data_saturate_enable;
    logic legacy_compat_mode;
  } dha_mode_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] word_at_addr;
    logic [WORD_W-1:0] word_even_pair;
    logic [WORD_W-1:0] word_odd_pair;
  } dha_mem_t;

  typedef struct packed {
    logic [ACC_W-1:0] dest_accumulator;
    logic dest_acc_overflow_flag;
    logic carry;
  } dha_res_t;
endpackage : dha_pkg

/* src/dha_alu.sv */
// dual-lane 16/24-bit packed add and add-subtract alu
`timescale 1ns/10ps
module dha_alu #(
  parameter int LANE_LO_W = dha_pkg::LO_W,
  parameter int LANE_HI_W = dha_pkg::HI_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic issue,
  input wire logic use_opcode,
  input wire logic [dha_pkg::INSTR_W-1:0] instr,
  input wire dha_pkg::dha_op_t op,
  input wire dha_pkg::dha_mode_t mode,
  input wire dha_pkg::dha_mem_t mem,
  input wire logic [dha_pkg::ACC_W-1:0] source_accumulator,
  input wire logic [dha_pkg::WORD_W-1:0] temp_value,
  input wire logic acc_overflow_flag,
  output dha_pkg::dha_res_t result,
  output logic result_valid,
  output logic opcode_bad
);
  import dha_pkg::*;

  // lane arithmetic serves the 16/24 split only
  if (LANE_LO_W != LO_W) begin : g_bad_lo
    $error("dha_alu: low lane width must be 16");
  end
  if (LANE_HI_W != HI_W) begin : g_bad_hi
    $error("dha_alu: high lane width must be 24");
  end
  if (LANE_LO_W + LANE_HI_W != ACC_W) begin : g_bad_sum
    $error("dha_alu: lanes must fill the accumulator");
  end
  if (HI_W != WORD_W + GUARD_W) begin : g_bad_guard
    $error("dha_alu: guard bits must pad a word to the high lane");
  end
  if (HI_LANE_OVF_BIT < 0 || HI_LANE_OVF_BIT >= HI_W) begin : g_bad_ovf
    $error("dha_alu: high lane overflow bit out of range");
  end

  // extend a 16-bit word to the high lane width
  function automatic logic [HI_W-1:0] ext24(
    input logic [WORD_W-1:0] w,
    input logic sx
  );
    logic [GUARD_W-1:0] fill;
    fill = sx ? {GUARD_W{w[WORD_W-1]}} : {GUARD_W{1'b0}};
    ext24 = {fill, w};
  endfunction : ext24

  // low lane sum or difference; its carry is never used
  function automatic logic [LO_W-1:0] lo_sum(
    input logic [LO_W-1:0] a,
    input logic [LO_W-1:0] b,
    input logic sub
  );
    logic [LO_W-1:0] bb;
    bb = sub ? ~b : b;
    lo_sum = a + bb + {{(LO_W-1){1'b0}}, sub};
  endfunction : lo_sum

  // signed overflow of the low lane
  function automatic logic lo_ovf(
    input logic [LO_W-1:0] a,
    input logic [LO_W-1:0] b,
    input logic sub,
    input logic [LO_W-1:0] s
  );
    logic bsign;
    bsign = sub ? ~b[OVF_LO_BIT] : b[OVF_LO_BIT];
    lo_ovf = (a[OVF_LO_BIT] == bsign) && (s[OVF_LO_BIT] != a[OVF_LO_BIT]);
  endfunction : lo_ovf

  // operand sign matches the direction of any overflow
  function automatic logic [LO_W-1:0] lo_clamp(
    input logic neg
  );
    lo_clamp = neg ? LO_SAT_NEG : LO_SAT_POS;
  endfunction : lo_clamp

  // bits 39..31 must agree, else the sum left the 32-bit signed range
  function automatic logic hi_ovf(
    input logic [HI_W-1:0] r
  );
    logic [HI_W-1-HI_LANE_OVF_BIT:0] top;
    top = r[HI_W-1:HI_LANE_OVF_BIT];
    hi_ovf = ~(&top) & (|top);
  endfunction : hi_ovf

  // carry out of accumulator bit 31, i.e. out of high lane bit 15
  function automatic logic hi_carry(
    input logic [HI_W-1:0] a,
    input logic [HI_W-1:0] b
  );
    logic [HI_LANE_CARRY_BIT+1:0] part;
    part = {1'b0, a[HI_LANE_CARRY_BIT:0]} + {1'b0, b[HI_LANE_CARRY_BIT:0]};
    hi_carry = part[HI_LANE_CARRY_BIT+1];
  endfunction : hi_carry

  // clamp by the top guard bit of the wrapped sum
  function automatic logic [HI_W-1:0] hi_clamp(
    input logic neg
  );
    hi_clamp = neg ? HI_SAT_NEG : HI_SAT_POS;
  endfunction : hi_clamp

  // opcode byte and sub-op field of a temp-register dual form
  function automatic logic opc_match(
    input logic [INSTR_W-1:0] i,
    input logic [SUBOP_MSB-SUBOP_LSB:0] sub
  );
    logic byte_ok;
    logic sub_ok;
    byte_ok = i[INSTR_W-1 -: OPC_W] == OPC_TMP_DUAL;
    sub_ok = i[SUBOP_MSB:SUBOP_LSB] == sub;
    opc_match = byte_ok && sub_ok;
  endfunction : opc_match

  logic [WORD_W-1:0] msw;
  logic [WORD_W-1:0] lsw;
  logic [HI_W-1:0] hi_a;
  logic [HI_W-1:0] hi_b;
  logic [LO_W-1:0] lo_a;
  logic [LO_W-1:0] lo_b;
  logic lo_sub;
  logic sat_eff;
  logic [LO_W-1:0] lo_raw;
  logic lo_ov_raw;
  logic lo_ov;
  logic [LO_W-1:0] lo_res;
  logic [HI_W-1:0] hi_raw;
  logic hi_ov;
  logic hi_cy;
  logic [HI_W-1:0] hi_res;
  logic ovf_any;
  dha_op_t op_eff;
  logic op_ok;
  logic take;
  logic [LO_W-1:0] acc_lo_q;
  logic [HI_W-1:0] acc_hi_q;
  logic carry_q;
  logic ovf_flag_q;

  // opcode decode overrides the op port when requested
  always_comb begin
    op_eff = op;
    op_ok = 1'b1;
    if (use_opcode) begin
      if (opc_match(instr, SUB_ADD_TMP)) begin
        op_eff = DHA_OP_ADD_TMP_DBL;
        op_ok = 1'b1;
      end else if (opc_match(instr, SUB_MIX_DBL)) begin
        op_eff = DHA_OP_MIX_TMP_DBL;
        op_ok = 1'b1;
      end else begin
        // unknown encodings are refused, never guessed at
        op_eff = op;
        op_ok = 1'b0;
      end
    end
  end

  assign take = issue & op_ok;

  // word order of a double operand depends on the address parity
  always_comb begin
    msw = mem.word_at_addr;
    if (mem.addr[0]) begin
      lsw = mem.word_odd_pair;
    end else begin
      lsw = mem.word_even_pair;
    end
  end

  // operand steering per form
  always_comb begin
    hi_a = ext24(msw, mode.sign_extend_mode);
    lo_a = lsw;
    hi_b = ext24(temp_value, mode.sign_extend_mode);
    lo_b = temp_value;
    lo_sub = 1'b0;
    case (op_eff)
      DHA_OP_ADD_ACC_DBL: begin
        hi_a = ext24(msw, mode.sign_extend_mode);
        lo_a = lsw;
        hi_b = source_accumulator[ACC_W-1:LO_W];
        lo_b = source_accumulator[LO_W-1:0];
        lo_sub = 1'b0;
      end
      DHA_OP_ADD_TMP_DBL: begin
        hi_a = ext24(msw, mode.sign_extend_mode);
        lo_a = lsw;
        hi_b = ext24(temp_value, mode.sign_extend_mode);
        lo_b = temp_value;
        lo_sub = 1'b0;
      end
      DHA_OP_MIX_TMP_SGL: begin
        hi_a = ext24(mem.word_at_addr, mode.sign_extend_mode);
        lo_a = mem.word_at_addr;
        hi_b = ext24(temp_value, mode.sign_extend_mode);
        lo_b = temp_value;
        lo_sub = 1'b1;
      end
      DHA_OP_MIX_TMP_DBL: begin
        hi_a = ext24(msw, mode.sign_extend_mode);
        lo_a = lsw;
        hi_b = ext24(temp_value, mode.sign_extend_mode);
        lo_b = temp_value;
        lo_sub = 1'b1;
      end
      default: begin
        lo_sub = 1'b0;
      end
    endcase
  end

  // legacy mode forces saturation off for this datapath only
  assign sat_eff = mode.data_saturate_enable & ~mode.legacy_compat_mode;

  // low lane: sum, overflow, optional clamp
  always_comb begin
    lo_raw = lo_sum(lo_a, lo_b, lo_sub);
    lo_ov_raw = lo_ovf(lo_a, lo_b, lo_sub, lo_raw);
    lo_ov = lo_ov_raw & ~mode.legacy_compat_mode;
    if (lo_ov_raw && sat_eff) begin
      lo_res = lo_clamp(lo_a[OVF_LO_BIT]);
    end else begin
      lo_res = lo_raw;
    end
  end

  // high lane: guard bits ride along in the 24-bit sum
  always_comb begin
    hi_raw = hi_a + hi_b;
    hi_ov = hi_ovf(hi_raw);
    hi_cy = hi_carry(hi_a, hi_b);
    if (hi_ov && sat_eff) begin
      hi_res = hi_clamp(hi_raw[HI_W-1]);
    end else begin
      hi_res = hi_raw;
    end
  end

  // either lane may raise the flag; legacy mode masks the low lane
  assign ovf_any = hi_ov | lo_ov;

  // low half; both halves land on the same edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc_lo_q <= ACC_RST[LO_W-1:0];
    end else if (take) begin
      acc_lo_q <= lo_res;
    end
  end

  // high half with the guard bits
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc_hi_q <= ACC_RST[ACC_W-1:LO_W];
    end else if (take) begin
      acc_hi_q <= hi_res;
    end
  end

  // carry comes from the high lane only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      carry_q <= 1'b0;
    end else if (take) begin
      carry_q <= hi_cy;
    end
  end

  // sticky: an overflow only sets it, otherwise the old flag passes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ovf_flag_q <= 1'b0;
    end else if (take) begin
      ovf_flag_q <= acc_overflow_flag | ovf_any;
    end
  end

  // one answer pulse per accepted issue
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      result_valid <= 1'b0;
    end else begin
      result_valid <= take;
    end
  end

  // refusal pulse; the result registers keep their value
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      opcode_bad <= 1'b0;
    end else begin
      opcode_bad <= issue & ~op_ok;
    end
  end

  assign result.dest_accumulator = {acc_hi_q, acc_lo_q};
  assign result.dest_acc_overflow_flag = ovf_flag_q;
  assign result.carry = carry_q;
endmodule : dha_alu

/* test/dha_alu_sva.sv */
// port assertions for the dual-lane alu
`timescale 1ns/10ps
module dha_alu_sva (
  input wire logic clk,
  input wire logic rstn,
  input wire logic issue,
  input wire logic use_opcode,
  input wire logic acc_overflow_flag,
  input wire logic result_valid,
  input wire logic opcode_bad,
  input wire logic [23:0] instr,
  input wire logic [39:0] source_accumulator,
  input wire dha_pkg::dha_op_t op,
  input wire dha_pkg::dha_mode_t mode,
  input wire dha_pkg::dha_mem_t mem,
  input wire dha_pkg::dha_res_t result
);
  import dha_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire go = issue && !use_opcode;
  wire dec = issue && use_opcode;
  wire opc_ok = instr[23:16] == OPC_TMP_DUAL;
  // saturation off so both lanes wrap and the sums can be predicted here
  wire add_acc = go && op == DHA_OP_ADD_ACC_DBL && !mode.data_saturate_enable;
  property p_valid; go |=> result_valid && !opcode_bad; endproperty
  a_valid: assert property (p_valid) else $error("no answer");
  property p_idle; !issue |=> !result_valid && !opcode_bad && $stable(result); endproperty
  a_idle: assert property (p_idle) else $error("output moved");
  property p_bad; dec && !opc_ok |=> opcode_bad && !result_valid && $stable(result); endproperty
  a_bad: assert property (p_bad) else $error("bad opcode taken");
  property p_opc; dec && opc_ok && instr[3:1] == SUB_MIX_DBL |=> result_valid; endproperty
  a_opc: assert property (p_opc) else $error("opcode refused");
  property p_keep; go && acc_overflow_flag |=> result.dest_acc_overflow_flag; endproperty
  a_keep: assert property (p_keep) else $error("flag cleared");
  property p_lo_even; add_acc && !mem.addr[0] |=> result.dest_accumulator[15:0] ==
    $past(source_accumulator[15:0]) + $past(mem.word_even_pair); endproperty
  a_lo_even: assert property (p_lo_even) else $error("low lane even");
  property p_lo_odd; add_acc && mem.addr[0] |=> result.dest_accumulator[15:0] ==
    $past(source_accumulator[15:0]) + $past(mem.word_odd_pair); endproperty
  a_lo_odd: assert property (p_lo_odd) else $error("low lane odd");
  property p_hi; add_acc |=> result.dest_accumulator[31:16] ==
    $past(source_accumulator[31:16]) + $past(mem.word_at_addr); endproperty
  a_hi: assert property (p_hi) else $error("high lane");
  c_mix: cover property (issue && op == DHA_OP_MIX_TMP_SGL);
  c_bad: cover property (opcode_bad);
  c_ovf: cover property ($rose(result.dest_acc_overflow_flag));
endmodule : dha_alu_sva
bind dha_alu dha_alu_sva u_sva (.*);

/* test/dha_mem_model.sv */
// operand memory model for the alu's word inputs
`timescale 1ns/10ps
module dha_mem_model (
  input wire logic [15:0] addr,
  output dha_pkg::dha_mem_t mem
);
  logic [15:0] ram [16];
  // four address bits only; neighbour words wrap inside the table
  assign mem = {addr, ram[addr[3:0]], ram[addr[3:0] + 4'h1], ram[addr[3:0] - 4'h1]};
endmodule : dha_mem_model

/* test/tb_dual_half_add_sub_alu.sv */
// self-checking bench for the dual-lane add/sub alu
`timescale 1ns/10ps
module tb_dual_half_add_sub_alu;
  import dha_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, issue = 1'b0, use_opcode = 1'b0, acc_overflow_flag = 1'b0;
  logic [23:0] instr = 24'h00_0000;
  logic [15:0] addr = 16'h0000, temp_value = 16'h0000;
  logic [39:0] source_accumulator = 40'h00_1234_0001;
  dha_op_t op = DHA_OP_ADD_ACC_DBL;
  dha_mode_t mode = 3'b000;
  dha_mem_t mem;
  dha_res_t result;
  logic result_valid, opcode_bad;
  int err_count = 0, n_checks = 0;
  dha_mem_model mm (
    .addr(addr),
    .mem(mem)
  );
  dha_alu uut (
    .clk(clk),
    .rstn(rstn),
    .issue(issue),
    .use_opcode(use_opcode),
    .instr(instr),
    .op(op),
    .mode(mode),
    .mem(mem),
    .source_accumulator(source_accumulator),
    .temp_value(temp_value),
    .acc_overflow_flag(acc_overflow_flag),
    .result(result),
    .result_valid(result_valid),
    .opcode_bad(opcode_bad)
  );
  initial forever #5 clk = ~clk;
  task automatic chk(string n, logic [42:0] s, logic [42:0] e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // fl packs old flag, expected flag, expected carry
  task automatic run(dha_op_t o, dha_mode_t m, logic [3:0] a, logic [15:0] hi, lo, t,
    logic [39:0] want, logic [2:0] fl);
    @(posedge clk) #1;
    mm.ram[a] = hi;
    mm.ram[a[0] ? a - 4'h1 : a + 4'h1] = lo;
    op = o;
    {mode, addr, temp_value, acc_overflow_flag, issue} = {m, 12'h000, a, t, fl[2], 1'b1};
    @(posedge clk) #1;
    issue = 1'b0;
    chk("result", {result, result_valid}, {want, fl[1:0], 1'b1});
  endtask : run
  task t_lanes;
    run(DHA_OP_ADD_ACC_DBL, 3'b000, 4'h4, 16'h8100, 16'h0002, 16'h0000,
      40'h00_9334_0003, 3'b010);
    run(DHA_OP_ADD_ACC_DBL, 3'b100, 4'h5, 16'h0002, 16'h0100, 16'h0000,
      40'h00_1236_0101, 3'b110);
    run(DHA_OP_ADD_TMP_DBL, 3'b110, 4'h2, 16'h0000, 16'h7fff, 16'h0001,
      40'h00_0001_7fff, 3'b010);
    run(DHA_OP_ADD_TMP_DBL, 3'b110, 4'h2, 16'h8000, 16'h0000, 16'h8000,
      40'hff_8000_8000, 3'b011);
    run(DHA_OP_ADD_TMP_DBL, 3'b111, 4'h2, 16'h0000, 16'h7fff, 16'h0001,
      40'h00_0001_8000, 3'b000);
    $display("test lanes done");
  endtask : t_lanes
  task t_decode;
    run(DHA_OP_MIX_TMP_SGL, 3'b100, 4'h6, 16'he300, 16'he300, 16'h4000,
      40'h00_2300_a300, 3'b001);
    use_opcode = 1'b1;
    instr = {OPC_TMP_DUAL, 12'h000, SUB_MIX_DBL, 1'b0};
    run(DHA_OP_ADD_ACC_DBL, 3'b100, 4'h2, 16'h0200, 16'h0300, 16'h0001,
      40'h00_0201_02ff, 3'b000);
    @(posedge clk) #1;
    {instr, issue} = {24'h00_0000, 1'b1};
    @(posedge clk) #1;
    issue = 1'b0;
    chk("refused", {result.dest_accumulator, result_valid, opcode_bad},
      {40'h00_0201_02ff, 2'b01});
    instr = {OPC_TMP_DUAL, 12'h000, SUB_ADD_TMP, 1'b0};
    run(DHA_OP_MIX_TMP_SGL, 3'b000, 4'h8, 16'h0100, 16'h0010, 16'h0002,
      40'h00_0102_0012, 3'b000);
    @(posedge clk) #1;
    {instr, issue} = {OPC_TMP_DUAL, 12'h000, 3'b101, 1'b0, 1'b1};
    @(posedge clk) #1;
    issue = 1'b0;
    chk("bad subop", {result.dest_accumulator, result_valid, opcode_bad},
      {40'h00_0102_0012, 2'b01});
    use_opcode = 1'b0;
    $display("test decode done");
  endtask : t_decode
  task t_reset;
    @(posedge clk) #1;
    rstn = 1'b0;
    @(posedge clk) #1;
    chk("reset", {result, result_valid}, 43'h0);
    chk("reset bad", {42'h0, opcode_bad}, 43'h0);
    rstn = 1'b1;
    run(DHA_OP_ADD_ACC_DBL, 3'b000, 4'h2, 16'h0001, 16'h0001, 16'h0000,
      40'h00_1235_0002, 3'b000);
    $display("test reset done");
  endtask : t_reset
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  initial begin
    repeat (4) @(posedge clk);
    #1 rstn = 1'b1;
    t_lanes();
    t_decode();
    t_reset();
    complete_run();
  end
endmodule : tb_dual_half_add_sub_alu
